// ### inc/wdt_pkg.sv
// Constants for the write-once option registers and the watchdog.
// Assumes one clock, aclk, that also stands for the crystal clock.
// Behaviour
// - Option registers take one write per reset
// - Reset clears options except supply-range select
// - Supply-range select cleared only by power-on
// - Oscillator runs in stop when enabled
// - Serial clock: bus clock or oscillator
// - Rate bit picks short or long timeout
// - Monitor runs in stop when enabled and not powered down
// - Reset-disable bit blocks monitor resets
// - Power-disable bit switches monitor off
// - Supply-range bit selects 5 V or 3 V
// - Short recovery 32 cycles, else 4096
// - External reset exit always uses long recovery
// - Stop disabled means illegal opcode
// - Disable bit stops watchdog resets
// - Six-bit counter behind twelve-bit prescaler overflows
// - Service write clears counter and upper prescaler
// - Service read returns reset vector low byte
// - Watchdog reset: pin low 32, cause flag
// - Watchdog off under test voltage conditions
// - Stop instruction clears the prescaler when stop is enabled
// - Prescaler cleared 4096 cycles after power-up
// - Internal reset clears prescaler and counter
// - No counting during stop mode
// - Reset vector fetch clears the prescaler
`default_nettype none

package wdt_pkg;

	// Bus geometry and register word indices
	localparam int unsigned ADDR_W              = 18;
	localparam int unsigned DATA_W              = 32;
	localparam logic [17:0] IDX_OPTION_ONE      = 18'h0_001f;
	localparam logic [17:0] IDX_OPTION_TWO      = 18'h0_001e;
	localparam logic [17:0] IDX_WATCHDOG_SVC    = 18'h0_ffff;
	localparam logic [17:0] IDX_RESET_CAUSE     = 18'h0_0020;
	localparam logic [17:0] ADDR_OPTION_ONE     = 18'(IDX_OPTION_ONE << 2);
	localparam logic [17:0] ADDR_OPTION_TWO     = 18'(IDX_OPTION_TWO << 2);
	localparam logic [17:0] ADDR_WATCHDOG_SVC   = 18'(IDX_WATCHDOG_SVC << 2);
	localparam logic [17:0] ADDR_RESET_CAUSE    = 18'(IDX_RESET_CAUSE << 2);
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_SLVERR         = 2'h2;

	// Option register one fields
	localparam int unsigned OPT1_RATE           = 7;
	localparam int unsigned OPT1_MON_IN_STOP    = 6;
	localparam int unsigned OPT1_MON_RST_DIS    = 5;
	localparam int unsigned OPT1_MON_PWR_DIS    = 4;
	localparam int unsigned OPT1_RANGE          = 3;
	localparam int unsigned OPT1_SHORT_REC      = 2;
	localparam int unsigned OPT1_STOP_EN        = 1;
	localparam int unsigned OPT1_WD_DIS         = 0;

	// Option register two fields
	localparam int unsigned OPT2_OSC_IN_STOP    = 1;
	localparam int unsigned OPT2_SERIAL_SRC     = 0;
	localparam logic [7:0]  OPT2_USED_MASK      = 8'h03;

	// Reset cause register fields
	localparam int unsigned CAUSE_WATCHDOG      = 0;

	// Watchdog timing, in crystal cycles
	localparam int unsigned PRESCALE_W          = 12;
	localparam int unsigned COUNTER_W           = 6;
	localparam int unsigned FAST_TAP_W          = 7;
	localparam int unsigned TIMEOUT_SHORTFALL   = 16;
	localparam logic [11:0] SERVICE_CLEAR_MASK  = 12'h0ff0;
	localparam int unsigned RESET_PIN_CYCLES    = 32;
	localparam int unsigned POR_CLEAR_CYCLES    = 4096;
	localparam logic [12:0] RECOVERY_SHORT      = 13'h0020;
	localparam logic [12:0] RECOVERY_LONG       = 13'h1000;

endpackage : wdt_pkg

`default_nettype wire

// ### logic/reset_stretcher.sv
// Stretches a one-cycle reset request into a fixed-length pin pulse.
// Assumes the request comes from logic on the same clock.
`default_nettype none

module reset_stretcher #(
	parameter int unsigned CYCLES = 32
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Request and pin
	input  wire logic request,
	output var  logic pin_low_q
);

	localparam int unsigned CNT_W = $clog2(CYCLES + 1);
	localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);

	logic [CNT_W-1:0] remain_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remain_q <= '0;
		end else if (request) begin
			remain_q <= LOAD;
		end else if (remain_q != '0) begin
			remain_q <= remain_q - CNT_W'(1);
		end
	end

	// Pin is low exactly while the count runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_low_q <= 1'b0;
		end else begin
			pin_low_q <= request || (remain_q > CNT_W'(1));
		end
	end

endmodule : reset_stretcher

`default_nettype wire

// ### logic/write_once_config_and_watchdog.sv
// Write-once option registers and the watchdog they configure.
// Assumes aclk is the crystal clock and aresetn is the power-on reset;
// other internal resets arrive as a one-cycle pulse on internal_reset.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module write_once_config_and_watchdog #(
	parameter int unsigned PRE_W            = wdt_pkg::PRESCALE_W,
	parameter int unsigned CNT_W            = wdt_pkg::COUNTER_W,
	parameter int unsigned POR_DELAY        = wdt_pkg::POR_CLEAR_CYCLES,
	parameter int unsigned RST_CYCLES       = wdt_pkg::RESET_PIN_CYCLES,
	parameter logic [7:0]  RESET_VECTOR_LOW = 8'h00
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [17:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [17:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// System events
	input  wire logic        internal_reset,
	input  wire logic        stop_instr,
	input  wire logic        stop_mode,
	input  wire logic        stop_exit_by_reset,
	input  wire logic        vector_fetch,
	input  wire logic        monitor_mode,
	input  wire logic        break_state,
	// Test voltage detectors on the reset and interrupt pins
	input  wire logic        test_voltage_level_rst,
	input  wire logic        test_voltage_level_irq,
	// Voltage monitor
	input  wire logic        voltage_monitor_reset_req,
	output var  logic        voltage_monitor_reset_q,
	output var  logic        voltage_monitor_power_on_q,
	output var  logic        voltage_monitor_stop_run_q,
	output var  logic        voltage_monitor_trip_5v_q,
	// Clocking options
	output var  logic        osc_enable_q,
	output var  logic        serial_clock_internal_q,
	// Stop control
	output var  logic        stop_honoured_q,
	output var  logic        stop_illegal_q,
	output var  logic [12:0] stop_recovery_cycles_q,
	// Watchdog reset
	output var  logic        watchdog_reset_req_q,
	output var  logic        reset_pin_o,
	output var  logic        reset_pin_oe_q
);

	localparam logic [PRE_W-1:0] PRE_ALL   = '1;
	localparam logic [CNT_W-1:0] CNT_ALL   = '1;
	localparam logic [PRE_W-1:0] TERM_SLOW =
		PRE_W'((2 ** PRE_W) - wdt_pkg::TIMEOUT_SHORTFALL - 1);
	localparam logic [PRE_W-1:0] TERM_FAST =
		PRE_W'((2 ** wdt_pkg::FAST_TAP_W) - wdt_pkg::TIMEOUT_SHORTFALL - 1);
	localparam logic [PRE_W-1:0] FAST_MASK =
		PRE_W'((2 ** wdt_pkg::FAST_TAP_W) - 1);
	localparam int unsigned POR_W = $clog2(POR_DELAY + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_DELAY);

	// Bus state
	logic [17:0] wr_addr_q;
	logic [31:0] wr_data_q;
	logic        wr_lane0_q;
	logic        wr_en;
	logic        wr_opt1;
	logic        wr_opt2;
	logic        wr_svc;
	logic        wr_cause;
	logic        wr_hit;
	logic [31:0] rd_value;
	logic        rd_hit;

	// Option state
	logic [7:0]  opt1_q;
	logic [7:0]  opt2_q;
	logic        opt1_done_q;
	logic        opt2_done_q;
	logic        range_q;
	logic        range_done_q;
	logic        cause_q;

	// Test voltage synchronisers
	logic [1:0]  tst_rst_sync_q;
	logic [1:0]  tst_irq_sync_q;
	logic        tst_rst;
	logic        tst_irq;

	// Watchdog state
	logic [PRE_W-1:0] pre_q;
	logic [CNT_W-1:0] cnt_q;
	logic [POR_W-1:0] por_cnt_q;
	logic             por_clear_q;
	logic             wd_off;
	logic             tick;
	logic             overflow;
	logic             pre_clear;

	// Write channels: each address and data is held until the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			wr_addr_q     <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			wr_addr_q     <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			wr_data_q    <= '0;
			wr_lane0_q   <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wr_data_q    <= s_axi_wdata;
			wr_lane0_q   <= s_axi_wstrb[0];
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	assign wr_en    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_opt1  = wr_en && wr_lane0_q && (wr_addr_q == wdt_pkg::ADDR_OPTION_ONE);
	assign wr_opt2  = wr_en && wr_lane0_q && (wr_addr_q == wdt_pkg::ADDR_OPTION_TWO);
	assign wr_svc   = wr_en && (wr_addr_q == wdt_pkg::ADDR_WATCHDOG_SVC);
	assign wr_cause = wr_en && wr_lane0_q && (wr_addr_q == wdt_pkg::ADDR_RESET_CAUSE);
	assign wr_hit   = (wr_addr_q == wdt_pkg::ADDR_OPTION_ONE)
		|| (wr_addr_q == wdt_pkg::ADDR_OPTION_TWO)
		|| (wr_addr_q == wdt_pkg::ADDR_WATCHDOG_SVC)
		|| (wr_addr_q == wdt_pkg::ADDR_RESET_CAUSE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= wdt_pkg::RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode
	always_comb begin
		rd_value = '0;
		rd_hit   = 1'b1;
		unique case (s_axi_araddr)
			wdt_pkg::ADDR_OPTION_ONE: begin
				rd_value[7:0] = {opt1_q[7:4], range_q, opt1_q[2:0]};
			end
			wdt_pkg::ADDR_OPTION_TWO: begin
				rd_value[7:0] = opt2_q;
			end
			wdt_pkg::ADDR_WATCHDOG_SVC: begin
				rd_value[7:0] = RESET_VECTOR_LOW;
			end
			wdt_pkg::ADDR_RESET_CAUSE: begin
				rd_value[wdt_pkg::CAUSE_WATCHDOG] = cause_q;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= wdt_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_value;
			s_axi_rresp   <= rd_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Option registers: first write after reset sticks
	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset) begin
			opt1_q      <= '0;
			opt1_done_q <= 1'b0;
		end else if (wr_opt1 && !opt1_done_q) begin
			opt1_q      <= wr_data_q[7:0];
			opt1_done_q <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset) begin
			opt2_q      <= '0;
			opt2_done_q <= 1'b0;
		end else if (wr_opt2 && !opt2_done_q) begin
			opt2_q      <= wr_data_q[7:0] & wdt_pkg::OPT2_USED_MASK;
			opt2_done_q <= 1'b1;
		end
	end

	// Supply-range bit survives internal resets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range_q      <= 1'b0;
			range_done_q <= 1'b0;
		end else if (wr_opt1 && !range_done_q) begin
			range_q      <= wr_data_q[wdt_pkg::OPT1_RANGE];
			range_done_q <= 1'b1;
		end
	end

	// Cause flag: set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_q <= 1'b0;
		end else if (overflow) begin
			cause_q <= 1'b1;
		end else if (wr_cause && wr_data_q[wdt_pkg::CAUSE_WATCHDOG]) begin
			cause_q <= 1'b0;
		end
	end

	// Pin-level detectors cross into aclk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tst_rst_sync_q <= '0;
			tst_irq_sync_q <= '0;
		end else begin
			tst_rst_sync_q <= {tst_rst_sync_q[0], test_voltage_level_rst};
			tst_irq_sync_q <= {tst_irq_sync_q[0], test_voltage_level_irq};
		end
	end

	assign tst_rst = tst_rst_sync_q[1];
	assign tst_irq = tst_irq_sync_q[1];

	// One clear of the prescaler a fixed time after power-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_cnt_q   <= '0;
			por_clear_q <= 1'b0;
		end else if (por_cnt_q != POR_LAST) begin
			por_cnt_q   <= por_cnt_q + POR_W'(1);
			por_clear_q <= (por_cnt_q == POR_LAST - POR_W'(1));
		end else begin
			por_clear_q <= 1'b0;
		end
	end

	// Watchdog enables and events
	assign wd_off = opt1_q[wdt_pkg::OPT1_WD_DIS]
		|| (monitor_mode && (tst_rst || tst_irq))
		|| (break_state && tst_rst);

	assign tick = opt1_q[wdt_pkg::OPT1_RATE]
		? ((pre_q & FAST_MASK) == FAST_MASK)
		: (pre_q == PRE_ALL);

	assign overflow = !wd_off && !stop_mode && (cnt_q == CNT_ALL)
		&& (opt1_q[wdt_pkg::OPT1_RATE]
			? ((pre_q & FAST_MASK) == TERM_FAST)
			: (pre_q == TERM_SLOW));

	assign pre_clear = (stop_instr && opt1_q[wdt_pkg::OPT1_STOP_EN])
		|| vector_fetch
		|| por_clear_q;

	// Prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset || wd_off || overflow) begin
			pre_q <= '0;
		end else if (pre_clear) begin
			pre_q <= '0;
		end else if (wr_svc) begin
			pre_q <= pre_q & ~PRE_W'(wdt_pkg::SERVICE_CLEAR_MASK);
		end else if (!stop_mode) begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// Six-bit counter
	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset || wd_off || overflow) begin
			cnt_q <= '0;
		end else if (wr_svc) begin
			cnt_q <= '0;
		end else if (!stop_mode && tick) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// One-cycle overflow request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_reset_req_q <= 1'b0;
		end else begin
			watchdog_reset_req_q <= overflow;
		end
	end

	// Reset pin drive, open drain
	reset_stretcher #(
		.CYCLES    (RST_CYCLES)
	) u_stretch (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.request   (overflow),
		.pin_low_q (reset_pin_oe_q)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_pin_o <= 1'b0;
		end else begin
			reset_pin_o <= 1'b0;
		end
	end

	// Stop instruction handling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_honoured_q <= 1'b0;
			stop_illegal_q  <= 1'b0;
		end else begin
			stop_honoured_q <= stop_instr && opt1_q[wdt_pkg::OPT1_STOP_EN];
			stop_illegal_q  <= stop_instr && !opt1_q[wdt_pkg::OPT1_STOP_EN];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_recovery_cycles_q <= wdt_pkg::RECOVERY_LONG;
		end else if (opt1_q[wdt_pkg::OPT1_SHORT_REC] && !stop_exit_by_reset) begin
			stop_recovery_cycles_q <= wdt_pkg::RECOVERY_SHORT;
		end else begin
			stop_recovery_cycles_q <= wdt_pkg::RECOVERY_LONG;
		end
	end

	// Voltage monitor controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			voltage_monitor_reset_q    <= 1'b0;
			voltage_monitor_power_on_q <= 1'b0;
			voltage_monitor_stop_run_q <= 1'b0;
			voltage_monitor_trip_5v_q  <= 1'b0;
		end else begin
			voltage_monitor_reset_q    <= voltage_monitor_reset_req
				&& !opt1_q[wdt_pkg::OPT1_MON_RST_DIS];
			voltage_monitor_power_on_q <= !opt1_q[wdt_pkg::OPT1_MON_PWR_DIS];
			voltage_monitor_stop_run_q <= opt1_q[wdt_pkg::OPT1_MON_IN_STOP]
				&& !opt1_q[wdt_pkg::OPT1_MON_PWR_DIS];
			voltage_monitor_trip_5v_q  <= range_q;
		end
	end

	// Clock options
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_enable_q            <= 1'b0;
			serial_clock_internal_q <= 1'b0;
		end else begin
			osc_enable_q            <= !stop_mode
				|| opt2_q[wdt_pkg::OPT2_OSC_IN_STOP];
			serial_clock_internal_q <= opt2_q[wdt_pkg::OPT2_SERIAL_SRC];
		end
	end

endmodule : write_once_config_and_watchdog

`default_nettype wire

// ### testbench/wdt_props.sv
// Checker for the option outputs and the watchdog reset path.
// Assumes it is bound into write_once_config_and_watchdog; one clock domain.
`default_nettype none

module wdt_props #(
	parameter int unsigned RST_CYCLES = 32
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Events
	input wire logic        stop_instr,
	input wire logic        stop_mode,
	input wire logic        stop_exit_by_reset,
	input wire logic        monitor_mode,
	input wire logic        test_voltage_level_rst,
	input wire logic        voltage_monitor_reset_req,
	// Outputs under watch
	input wire logic        voltage_monitor_reset_q,
	input wire logic        voltage_monitor_power_on_q,
	input wire logic        voltage_monitor_stop_run_q,
	input wire logic        osc_enable_q,
	input wire logic        stop_honoured_q,
	input wire logic        stop_illegal_q,
	input wire logic [12:0] stop_recovery_cycles_q,
	input wire logic        watchdog_reset_req_q,
	input wire logic        reset_pin_o,
	input wire logic        reset_pin_oe_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Length of the current pin pulse
	logic [15:0] oe_run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || !reset_pin_oe_q)
			oe_run_q <= 16'h0000;
		else
			oe_run_q <= oe_run_q + 16'h0001;
	end

	sequence s_test_hold;
		(monitor_mode && test_voltage_level_rst)[*6];
	endsequence
	sequence s_stop_answer;
		##1 (stop_honoured_q ^ stop_illegal_q);
	endsequence

	property p_vm_block;
		!voltage_monitor_reset_req |=> !voltage_monitor_reset_q;
	endproperty
	a_vm_block: assert property (p_vm_block) else $error("monitor reset unrequested");
	property p_vm_power;
		voltage_monitor_stop_run_q |-> voltage_monitor_power_on_q;
	endproperty
	a_vm_power: assert property (p_vm_power) else $error("monitor runs unpowered");
	property p_rec_vals;
		stop_recovery_cycles_q == 13'h0020 || stop_recovery_cycles_q == 13'h1000;
	endproperty
	a_rec_vals: assert property (p_rec_vals) else $error("odd recovery count");
	property p_rec_long;
		stop_exit_by_reset |=> stop_recovery_cycles_q == 13'h1000;
	endproperty
	a_rec_long: assert property (p_rec_long) else $error("short recovery on reset");
	property p_osc_run;
		aresetn && !stop_mode |=> osc_enable_q;
	endproperty
	a_osc_run: assert property (p_osc_run) else $error("oscillator off outside stop");
	property p_stop_answer;
		stop_instr |-> s_stop_answer;
	endproperty
	a_stop_answer: assert property (p_stop_answer) else $error("stop not answered");
	property p_stop_cause;
		(stop_honoured_q || stop_illegal_q) |-> $past(stop_instr);
	endproperty
	a_stop_cause: assert property (p_stop_cause) else $error("stop answer uncaused");
	property p_req_pulse;
		watchdog_reset_req_q |=> !watchdog_reset_req_q;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("request too long");
	property p_pin_start;
		watchdog_reset_req_q |-> ##[0:1] reset_pin_oe_q;
	endproperty
	a_pin_start: assert property (p_pin_start) else $error("pin not pulled");
	property p_pin_low;
		reset_pin_oe_q |-> !reset_pin_o;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin driven high");
	property p_pin_len;
		$fell(reset_pin_oe_q) |-> oe_run_q == 16'(RST_CYCLES);
	endproperty
	a_pin_len: assert property (p_pin_len) else $error("pin pulse length wrong");
	property p_test_off;
		s_test_hold |-> !watchdog_reset_req_q;
	endproperty
	a_test_off: assert property (p_test_off) else $error("watchdog fired in test");
endmodule : wdt_props

bind write_once_config_and_watchdog wdt_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

`default_nettype wire

// ### testbench/tb_write_once_config_and_watchdog.sv
// Self-checking bench for the option registers and the watchdog.
// Assumes the package, design and checker are compiled first.
`default_nettype none

module tb_write_once_config_and_watchdog;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned     RSTC  = 4;
	localparam logic [17:0]     OPT1  = wdt_pkg::ADDR_OPTION_ONE;
	localparam logic [17:0]     OPT2  = wdt_pkg::ADDR_OPTION_TWO;
	localparam logic [17:0]     SVC   = wdt_pkg::ADDR_WATCHDOG_SVC;
	localparam logic [17:0]     CAUSE = wdt_pkg::ADDR_RESET_CAUSE;
	localparam logic [1:0]      OKAY  = wdt_pkg::RESP_OKAY;
	logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        internal_reset = 1'h0, stop_instr = 1'h0, stop_mode = 1'h0;
	logic        stop_exit_by_reset = 1'h0, vector_fetch = 1'h0, monitor_mode = 1'h0;
	logic        break_state = 1'h0, test_voltage_level_rst = 1'h0;
	logic        test_voltage_level_irq = 1'h0, voltage_monitor_reset_req = 1'h0;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [17:0] s_axi_awaddr = 18'h0_0000, s_axi_araddr = 18'h0_0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        voltage_monitor_reset_q, voltage_monitor_power_on_q, reset_pin_oe_q;
	logic        voltage_monitor_stop_run_q, voltage_monitor_trip_5v_q, osc_enable_q;
	logic        serial_clock_internal_q, stop_honoured_q, stop_illegal_q;
	logic        watchdog_reset_req_q, reset_pin_o;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [12:0] stop_recovery_cycles_q;
	int          mismatches = 0, total_checks = 0, n;

	write_once_config_and_watchdog #(.POR_DELAY(16), .RST_CYCLES(RSTC),
		.RESET_VECTOR_LOW(8'ha5)) dut (.*);

	always #5 aclk = ~aclk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask : cyc

	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h00_0000, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		check("bresp", 32'(s_axi_bresp), 32'(OKAY));
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		check("rdata", s_axi_rdata, {24'h00_0000, e});
		check("rresp", 32'(s_axi_rresp), 32'(er));
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd

	// Counts watchdog requests over a span of cycles
	task automatic reqs_in(input int c, output int seen);
		seen = 0;
		repeat (c) begin
			@(posedge aclk);
			if (watchdog_reset_req_q === 1'h1)
				seen++;
		end
	endtask : reqs_in

	task automatic pulse_internal_reset();
		internal_reset <= 1'h1;
		cyc(1);
		internal_reset <= 1'h0;
	endtask : pulse_internal_reset

	task automatic t_after_reset();
		rd(OPT1, 8'h00, OKAY);
		rd(OPT2, 8'h00, OKAY);
		rd(SVC, 8'ha5, OKAY);
		rd(18'h0_0100, 8'h00, wdt_pkg::RESP_SLVERR);
		check("recovery", 32'(stop_recovery_cycles_q), 32'h0000_1000);
		check("power_on", 32'(voltage_monitor_power_on_q), 32'h1);
		check("trip_5v", 32'(voltage_monitor_trip_5v_q), 32'h0);
		check("serial", 32'(serial_clock_internal_q), 32'h0);
		voltage_monitor_reset_req <= 1'h1;
		stop_mode <= 1'h1;
		cyc(3);
		check("vm_reset", 32'(voltage_monitor_reset_q), 32'h1);
		check("osc", 32'(osc_enable_q), 32'h0);
		check("stop_run", 32'(voltage_monitor_stop_run_q), 32'h0);
		stop_mode <= 1'h0;
	endtask : t_after_reset

	task automatic t_write_once();
		wr(OPT1, 8'hee, 4'hf);
		rd(OPT1, 8'hee, OKAY);
		wr(OPT1, 8'h01, 4'hf);
		rd(OPT1, 8'hee, OKAY);
		wr(OPT2, 8'h03, 4'h0);
		rd(OPT2, 8'h00, OKAY);
		wr(OPT2, 8'h03, 4'hf);
		wr(OPT2, 8'h00, 4'hf);
		rd(OPT2, 8'h03, OKAY);
		check("trip_5v", 32'(voltage_monitor_trip_5v_q), 32'h1);
		check("serial", 32'(serial_clock_internal_q), 32'h1);
		check("recovery", 32'(stop_recovery_cycles_q), 32'h0000_0020);
		check("vm_reset", 32'(voltage_monitor_reset_q), 32'h0);
		stop_exit_by_reset <= 1'h1;
		stop_mode <= 1'h1;
		cyc(3);
		check("recovery", 32'(stop_recovery_cycles_q), 32'h0000_1000);
		check("osc", 32'(osc_enable_q), 32'h1);
		check("stop_run", 32'(voltage_monitor_stop_run_q), 32'h1);
		stop_exit_by_reset <= 1'h0;
		stop_mode <= 1'h0;
	endtask : t_write_once

	task automatic t_stop_hold();
		wr(SVC, 8'h00, 4'hf);
		stop_instr <= 1'h1;
		cyc(1);
		stop_instr <= 1'h0;
		cyc(1);
		check("honoured", 32'(stop_honoured_q), 32'h1);
		stop_mode <= 1'h1;
		reqs_in(8300, n);
		check("stop_count", 32'(n), 32'h0);
		stop_mode <= 1'h0;
	endtask : t_stop_hold

	task automatic t_timeout();
		wr(SVC, 8'h5a, 4'h0);
		vector_fetch <= 1'h1;
		cyc(1);
		vector_fetch <= 1'h0;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (watchdog_reset_req_q !== 1'h1 && n < 9000);
		check("timeout", 32'(n >= 8174 && n <= 8180), 32'h1);
		n = (reset_pin_oe_q === 1'h1) ? 1 : 0;
		repeat (RSTC + 4) begin
			@(posedge aclk);
			if (reset_pin_oe_q === 1'h1)
				n++;
		end
		check("pin_cycles", 32'(n), 32'(RSTC));
		rd(CAUSE, 8'h01, OKAY);
		wr(CAUSE, 8'h01, 4'hf);
		rd(CAUSE, 8'h00, OKAY);
	endtask : t_timeout

	task automatic t_internal();
		pulse_internal_reset();
		rd(OPT1, 8'h08, OKAY);
		rd(OPT2, 8'h00, OKAY);
		wr(OPT1, 8'h81, 4'hf);
		rd(OPT1, 8'h89, OKAY);
		stop_instr <= 1'h1;
		cyc(1);
		stop_instr <= 1'h0;
		cyc(1);
		check("illegal", 32'(stop_illegal_q), 32'h1);
		reqs_in(8300, n);
		check("disabled", 32'(n), 32'h0);
	endtask : t_internal

	task automatic t_test_voltage();
		pulse_internal_reset();
		wr(OPT1, 8'h80, 4'hf);
		for (int i = 0; i < 3; i++) begin
			monitor_mode           <= (i != 2);
			break_state            <= (i == 2);
			test_voltage_level_rst <= (i != 1);
			test_voltage_level_irq <= (i == 1);
			reqs_in(8300, n);
			check("test_voltage", 32'(n), 32'h0);
		end
	endtask : t_test_voltage

	initial begin
		#900_000;
		mismatches++;
		results();
	end

	initial begin
		cyc(2);
		aresetn <= 1'h1;
		t_after_reset();
		t_write_once();
		t_stop_hold();
		t_timeout();
		t_internal();
		t_test_voltage();
		results();
	end
endmodule : tb_write_once_config_and_watchdog

`default_nettype wire
